/* File: pkg/gdfh_pkg.sv */
package gdfh_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ          = 40;
	localparam int WARN_PULSE_NS    = 64000;
	localparam int FULL_RESET_NS    = 20000;
	localparam int WARN_PULSE_CYC   = (WARN_PULSE_NS * CLK_MHZ) / 1000;
	localparam int FULL_RESET_CYC   = (FULL_RESET_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W            = 12;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] STATUS_OFS  = 8'h00;
	localparam logic [7:0] CONTROL_OFS = 8'h04;
	localparam logic [7:0] LIVE_OFS    = 8'h08;

	// Status fields
	localparam int ST_OC_LSB      = 0;
	localparam int NUM_FET        = 6;
	localparam int ST_PWR_UV      = 6;
	localparam int ST_GATE_UV     = 7;
	localparam int ST_GATE_OV     = 8;
	localparam int ST_TEMP_WARN   = 9;
	localparam int ST_TEMP_SHDN   = 10;
	localparam int ST_OC_FAULT    = 11;
	localparam int ST_W           = 12;

	// Control fields
	localparam int CT_POLICY_LSB  = 0;
	localparam int CT_WSEL_LSB    = 2;
	localparam int CT_GATE_RESET  = 4;
	localparam logic [1:0] POLICY_RST = 2'h0;
	localparam logic [1:0] WSEL_RST   = 2'h0;

	// ----------------------------------------------------------------
	// Overcurrent policy and warning pin selection
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		POL_CUR_LIMIT = 2'h0,
		POL_LATCH     = 2'h1,
		POL_REPORT    = 2'h2,
		POL_DISABLED  = 2'h3
	} gdfh_policy_t;

	typedef enum logic [1:0] {
		WSEL_BOTH   = 2'h0,
		WSEL_TEMP   = 2'h1,
		WSEL_OC     = 2'h2,
		WSEL_BOTH_2 = 2'h3
	} gdfh_wsel_t;

endpackage

/* File: core/gdfh_sync.sv */
`timescale 1ns/100ps

module gdfh_sync
	import gdfh_pkg::*;
#(
	parameter int WIDTH = 1
)
(
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Asynchronous in, synchronous out
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;

	// ----------------------------------------------------------------
	// Two-stage synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_r   <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule

/* File: core/gdfh_fault_handler.sv */
// Contract
// - Report-only policy: no action, 64 us warning pulse, status bit set.
// - Disabled policy: overcurrent detections ignored, no action, no report anywhere; the live register still shows the overcurrent detector flags.
// - Power or gate supply undervolt: all gates low, unlatched, fault pin and status; the bus refuses reads under power undervolt, so that bit never reads set.
// - Power supply undervolt: ignore bus writes, registers return to defaults.
// - Gate supply overvolt: gates and charge pump off, latched, fault pin and status.
// - Overvolt latch cleared only by a full enable reset, not quick or command.
// - Warning pin reports temperature and overcurrent by default; selectable temperature-only or overcurrent-only.
// - Temperature warning: no action, unlatched, status and warning pin, never fault pin.
// - Temperature shutdown latches off; cleared by enable or command once cool.
// - Temperature shutdown: weak pulldown, charge pump off, both pins and status.
// - During temperature shutdown the bus works and settings are kept.
// - Fault pin asserts on shutdown events, released once gates are ready.
// - Warning pin asserts on overcurrent or temperature events, shutdown or not.
// - Current-limit policy: limit only the tripped transistor, unlatched, warning and status.
// - Latch policy: phase forced off, weak pulldown, latched, both pins and status.
// - Overcurrent status bits stay set until the next status read.
// - Latched fault and its status hold until gate reset command or quick enable pulse.
// - Enable rising edge clears latched faults and status unless condition persists.
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/100ps

module gdfh_fault_handler
	import gdfh_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int PHASES = 3
)
(
	// APB slave
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Analog detector flags
	input  wire logic [NUM_FET-1:0] oc_detect,
	input  wire logic              power_supply_undervolt,
	input  wire logic              gate_supply_undervolt,
	input  wire logic              digital_supply_undervolt,
	input  wire logic              gate_supply_overvolt,
	input  wire logic              temp_warning,
	input  wire logic              temp_shutdown,
	// Enable pin and PWM inputs
	input  wire logic              enable_gate,
	input  wire logic [PHASES-1:0] pwm_high,
	input  wire logic [PHASES-1:0] pwm_low,
	// Gate outputs
	output logic      [PHASES-1:0] high_gate_out,
	output logic      [PHASES-1:0] low_gate_out,
	output logic                   gate_weak_pulldown,
	output logic                   charge_pump_en,
	// Open-drain report pins
	output logic                   shutdown_fault_n_o,
	output logic                   shutdown_fault_n_oe,
	output logic                   warning_n_o,
	output logic                   warning_n_oe
);

	localparam int SYNC_W = NUM_FET + 7 + 2 * PHASES;

	// ----------------------------------------------------------------
	// Synchronisers
	// ----------------------------------------------------------------
	logic [SYNC_W-1:0]  sync_s;
	logic [NUM_FET-1:0] oc_s;
	logic               pwr_uv_s;
	logic               gate_uv_s;
	logic               dig_uv_s;
	logic               gate_ov_s;
	logic               temp_warn_s;
	logic               temp_shdn_s;
	logic               enable_s;
	logic [PHASES-1:0]  pwm_high_s;
	logic [PHASES-1:0]  pwm_low_s;

	gdfh_sync #(
		.WIDTH (SYNC_W)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({pwm_low, pwm_high, enable_gate, temp_shutdown, temp_warning,
			gate_supply_overvolt, digital_supply_undervolt, gate_supply_undervolt,
			power_supply_undervolt, oc_detect}),
		.sync_out (sync_s)
	);

	assign {pwm_low_s, pwm_high_s, enable_s, temp_shdn_s, temp_warn_s, gate_ov_s,
		dig_uv_s, gate_uv_s, pwr_uv_s, oc_s} = sync_s;

	// ----------------------------------------------------------------
	// Decoding helpers
	// ----------------------------------------------------------------
	function automatic logic wsel_temp(input logic [1:0] sel);
		wsel_temp = (sel != WSEL_OC);
	endfunction

	function automatic logic wsel_oc(input logic [1:0] sel);
		wsel_oc = (sel != WSEL_TEMP);
	endfunction

	// ----------------------------------------------------------------
	// Registers and state
	// ----------------------------------------------------------------
	logic [1:0]         policy_r;
	logic [1:0]         wsel_r;
	gdfh_policy_t       policy;
	logic [NUM_FET-1:0] oc_status_r;
	logic [NUM_FET-1:0] oc_prev_r;
	logic [PHASES-1:0]  phase_latch_r;
	logic [NUM_FET-1:0] cl_block_r;
	logic               ov_latch_r;
	logic               otsd_latch_r;
	logic               dig_uv_prev_r;
	logic               enable_prev_r;
	logic [CNT_W-1:0]   en_low_cnt_r;
	logic [CNT_W-1:0]   warn_cnt_r;
	logic [31:0]        prdata_r;

	logic               wr_access;
	logic               rd_access;
	logic               addr_hit;
	logic               gate_reset_cmd;
	logic               en_rise;
	logic               full_reset;
	logic               clear_latches;
	logic               clear_status;
	logic               status_read;
	logic               oc_report;
	logic [NUM_FET-1:0] oc_rise;
	logic               any_uv;
	logic               gate_enable;
	logic [ST_W-1:0]    status_word;

	assign policy = gdfh_policy_t'(policy_r);

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	assign addr_hit  = (paddr == STATUS_OFS) || (paddr == CONTROL_OFS) || (paddr == LIVE_OFS);
	assign wr_access = psel && penable && pwrite && addr_hit && !pwr_uv_s;
	assign rd_access = psel && penable && !pwrite && addr_hit;
	assign pready    = 1'b1;
	assign pslverr   = psel && penable && (!addr_hit || pwr_uv_s);
	assign prdata    = prdata_r;

	assign gate_reset_cmd = wr_access && (paddr == CONTROL_OFS) && pwdata[CT_GATE_RESET];
	assign status_read    = rd_access && (paddr == STATUS_OFS);

	// ----------------------------------------------------------------
	// Enable pin reset classification
	// ----------------------------------------------------------------
	assign en_rise    = enable_s && !enable_prev_r;
	assign full_reset = en_rise && (en_low_cnt_r >= CNT_W'(FULL_RESET_CYC));

	// Quick or full enable reset, or the gate reset command
	assign clear_latches = en_rise || gate_reset_cmd;
	assign clear_status  = clear_latches || (dig_uv_prev_r && !dig_uv_s);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			enable_prev_r <= 1'b0;
			dig_uv_prev_r <= 1'b0;
			en_low_cnt_r  <= '0;
		end
		else
		begin
			enable_prev_r <= enable_s;
			dig_uv_prev_r <= dig_uv_s;
			if (enable_s)
				en_low_cnt_r <= '0;
			else if (en_low_cnt_r < CNT_W'(FULL_RESET_CYC))
				en_low_cnt_r <= en_low_cnt_r + CNT_W'(1);
		end
	end

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			policy_r <= POLICY_RST;
			wsel_r   <= WSEL_RST;
		end
		else if (pwr_uv_s || full_reset)
		begin
			policy_r <= POLICY_RST;
			wsel_r   <= WSEL_RST;
		end
		else if (wr_access && (paddr == CONTROL_OFS))
		begin
			policy_r <= pwdata[CT_POLICY_LSB +: 2];
			wsel_r   <= pwdata[CT_WSEL_LSB +: 2];
		end
	end

	// ----------------------------------------------------------------
	// Overcurrent status and handling
	// ----------------------------------------------------------------
	assign oc_report = (policy != POL_DISABLED);
	assign oc_rise   = oc_s & ~oc_prev_r;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			oc_prev_r   <= '0;
			oc_status_r <= '0;
		end
		else if (pwr_uv_s)
		begin
			oc_prev_r   <= oc_s;
			oc_status_r <= '0;
		end
		else
		begin
			oc_prev_r <= oc_s;
			// Set wins over a read or reset clear
			if (oc_report)
				oc_status_r <= oc_s | (oc_status_r & ~{NUM_FET{status_read || clear_status}});
			else
				oc_status_r <= oc_status_r & ~{NUM_FET{status_read || clear_status}};
		end
	end

	// Per-transistor current limit and per-phase latch
	genvar g;
	generate
		for (g = 0; g < PHASES; g++)
		begin : g_phase
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					cl_block_r[2*g]   <= 1'b0;
					cl_block_r[2*g+1] <= 1'b0;
					phase_latch_r[g]  <= 1'b0;
				end
				else
				begin
					// Block the tripped transistor until its PWM input cycles
					if (policy == POL_CUR_LIMIT && oc_s[2*g])
						cl_block_r[2*g] <= 1'b1;
					else if (!pwm_high_s[g])
						cl_block_r[2*g] <= 1'b0;
					if (policy == POL_CUR_LIMIT && oc_s[2*g+1])
						cl_block_r[2*g+1] <= 1'b1;
					else if (!pwm_low_s[g])
						cl_block_r[2*g+1] <= 1'b0;
					if (policy == POL_LATCH && (oc_s[2*g] || oc_s[2*g+1]))
						phase_latch_r[g] <= 1'b1;
					else if (clear_latches)
						phase_latch_r[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Overvoltage and overtemperature latches
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ov_latch_r   <= 1'b0;
			otsd_latch_r <= 1'b0;
		end
		else
		begin
			if (gate_ov_s)
				ov_latch_r <= 1'b1;
			else if (full_reset)
				ov_latch_r <= 1'b0;
			if (temp_shdn_s)
				otsd_latch_r <= 1'b1;
			else if (clear_latches)
				otsd_latch_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Warning pulse timer
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			warn_cnt_r <= '0;
		else if (oc_report && (|oc_rise))
			warn_cnt_r <= CNT_W'(WARN_PULSE_CYC);
		else if (warn_cnt_r != '0)
			warn_cnt_r <= warn_cnt_r - CNT_W'(1);
	end

	// ----------------------------------------------------------------
	// Gate outputs
	// ----------------------------------------------------------------
	assign any_uv      = pwr_uv_s || gate_uv_s || dig_uv_s;
	assign gate_enable = enable_s && !any_uv && !ov_latch_r && !otsd_latch_r;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			high_gate_out      <= '0;
			low_gate_out       <= '0;
			gate_weak_pulldown <= 1'b1;
			charge_pump_en     <= 1'b0;
		end
		else
		begin
			for (int i = 0; i < PHASES; i++)
			begin
				high_gate_out[i] <= gate_enable && pwm_high_s[i] && !phase_latch_r[i]
					&& !cl_block_r[2*i];
				low_gate_out[i]  <= gate_enable && pwm_low_s[i] && !phase_latch_r[i]
					&& !cl_block_r[2*i+1];
			end
			gate_weak_pulldown <= !gate_enable || (|phase_latch_r);
			charge_pump_en     <= enable_s && !ov_latch_r && !otsd_latch_r;
		end
	end

	// ----------------------------------------------------------------
	// Report pins
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			shutdown_fault_n_oe <= 1'b1;
			warning_n_oe        <= 1'b0;
		end
		else
		begin
			// Held low until the gate driver is ready for PWM
			shutdown_fault_n_oe <= !enable_s || any_uv || ov_latch_r || otsd_latch_r
				|| (|phase_latch_r);
			warning_n_oe <= (wsel_oc(wsel_r) && (warn_cnt_r != '0))
				|| (wsel_temp(wsel_r) && temp_warn_s)
				|| otsd_latch_r;
		end
	end

	assign shutdown_fault_n_o = 1'b0;
	assign warning_n_o        = 1'b0;

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always_comb
	begin
		status_word                                = '0;
		status_word[ST_OC_LSB +: NUM_FET]          = oc_status_r;
		status_word[ST_PWR_UV]                     = pwr_uv_s;
		status_word[ST_GATE_UV]                    = gate_uv_s;
		status_word[ST_GATE_OV]                    = ov_latch_r;
		status_word[ST_TEMP_WARN]                  = temp_warn_s;
		status_word[ST_TEMP_SHDN]                  = otsd_latch_r;
		status_word[ST_OC_FAULT]                   = |phase_latch_r;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_r <= '0;
		else if (psel && !penable && !pwrite && !pwr_uv_s)
		begin
			prdata_r <= '0;
			unique case (paddr)
				STATUS_OFS:  prdata_r[ST_W-1:0] <= status_word;
				CONTROL_OFS: prdata_r[CT_WSEL_LSB+1:0] <= {wsel_r, policy_r};
				LIVE_OFS:    prdata_r[SYNC_W-1:0] <= sync_s;
				default:     prdata_r <= '0;
			endcase
		end
		else if (psel && !penable)
			prdata_r <= '0;
	end

endmodule

/* File: test/gdfh_mcu_model.sv */
`timescale 1ns/100ps

module gdfh_mcu_model
	import gdfh_pkg::*;
(
	// Clock
	input  wire logic pclk,
	// Device pin drivers
	input  wire logic fault_oe,
	input  wire logic warn_oe,
	// Bench requests
	input  wire logic req_quick,
	input  wire logic req_full,
	// Pins seen by the controller
	output logic      fault_pin_n,
	output logic      warn_pin_n,
	output logic      enable_gate,
	output logic      busy
);
	int cnt;

	// ------------------------------------------------------------
	// Pull-ups on both open-drain lines
	// ------------------------------------------------------------
	assign fault_pin_n = !fault_oe;
	assign warn_pin_n = !warn_oe;

	initial
	begin
		enable_gate = 1'b0;
		busy = 1'b0;
		cnt = 0;
	end

	// ------------------------------------------------------------
	// Enable pulses: quick, or low beyond the full reset time
	// ------------------------------------------------------------
	always @(posedge pclk)
	begin
		if (!busy && (req_quick || req_full))
		begin
			busy <= 1'b1;
			enable_gate <= 1'b0;
			cnt <= req_full ? FULL_RESET_CYC + 40 : 8;
		end
		else if (busy && cnt > 0)
			cnt <= cnt - 1;
		else if (busy)
		begin
			enable_gate <= 1'b1;
			busy <= 1'b0;
		end
	end
endmodule

/* File: test/gdfh_fault_handler_assertions.sv */
`timescale 1ns/100ps

module gdfh_fault_handler_assertions
	import gdfh_pkg::*;
#(
	parameter int PHASES = 3
)
(
	// Clock, reset and bus
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pslverr,
	// Detector flags and enable
	input wire logic              power_supply_undervolt,
	input wire logic              gate_supply_undervolt,
	input wire logic              digital_supply_undervolt,
	input wire logic              gate_supply_overvolt,
	input wire logic              temp_warning,
	input wire logic              temp_shutdown,
	input wire logic              enable_gate,
	// Outputs
	input wire logic [PHASES-1:0] high_gate_out,
	input wire logic [PHASES-1:0] low_gate_out,
	input wire logic              gate_weak_pulldown,
	input wire logic              charge_pump_en,
	input wire logic              shutdown_fault_n_o,
	input wire logic              shutdown_fault_n_oe,
	input wire logic              warning_n_o,
	input wire logic              warning_n_oe
);
	int unsigned wcnt_r;
	logic        wexc_r;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ------------------------------------------------------------
	// Warning pulse length and non-overcurrent causes
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wcnt_r <= 0;
			wexc_r <= 1'b0;
		end
		else
		begin
			wcnt_r <= warning_n_oe ? wcnt_r + 1 : 0;
			wexc_r <= temp_warning || temp_shutdown || digital_supply_undervolt
				|| (warning_n_oe && wexc_r);
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	uv_gates_low_a: assert property (
		(power_supply_undervolt || gate_supply_undervolt)[*5]
		|-> high_gate_out == '0 && low_gate_out == '0 && shutdown_fault_n_oe)
		else $error("gates not off under undervoltage");
	dig_uv_fault_a: assert property (
		digital_supply_undervolt[*5]
		|-> shutdown_fault_n_oe && gate_weak_pulldown && high_gate_out == '0)
		else $error("no shutdown on digital undervoltage");
	overvolt_off_a: assert property (
		gate_supply_overvolt[*5] |-> !charge_pump_en && shutdown_fault_n_oe)
		else $error("overvoltage did not stop charge pump");
	temp_shdn_pins_a: assert property (
		temp_shutdown[*5] |-> shutdown_fault_n_oe && warning_n_oe
		&& !charge_pump_en && gate_weak_pulldown)
		else $error("temperature shutdown not reported");
	temp_latch_hold_a: assert property (
		temp_shutdown[*5] ##1 (!temp_shutdown && enable_gate && !psel)[*8]
		|-> !charge_pump_en && shutdown_fault_n_oe)
		else $error("temperature shutdown recovered by itself");
	enable_low_fault_a: assert property (
		(!enable_gate)[*4] |-> shutdown_fault_n_oe && high_gate_out == '0
		&& low_gate_out == '0)
		else $error("fault pin released while not ready");
	uv_bus_refused_a: assert property (
		power_supply_undervolt[*4] ##0 (psel && penable) |-> pslverr)
		else $error("bus served under power undervoltage");
	drain_pins_low_a: assert property (
		!shutdown_fault_n_o && !warning_n_o)
		else $error("open-drain pin drives high");
	warn_pulse_len_a: assert property (
		$fell(warning_n_oe) && !wexc_r && enable_gate |-> wcnt_r >= WARN_PULSE_CYC)
		else $error("warning pulse too short");

	cover property ($rose(warning_n_oe));
	cover property ($fell(shutdown_fault_n_oe));
	cover property (psel && penable && pslverr);
endmodule

/* File: test/testbench.sv */
`timescale 1ns/100ps

module testbench
	import gdfh_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, pin_req;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [5:0]  oc;
	logic        pwr_uv, gate_uv, dig_uv, ov, tw, ts, rq, rf, busy, fpin, wpin, en;
	logic [2:0]  ph, pl, gh, gl, msk;
	logic        wpd, cp, f_o, f_oe, w_o, w_oe;
	logic [9:0]  ex;
	logic [32:0] rd_q[$], rd_m[$], pn_q[$], pn_m[$];
	int          errors, n_checks, k;

	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	gdfh_fault_handler gdfh_fault_handler_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .oc_detect(oc),
		.power_supply_undervolt(pwr_uv), .gate_supply_undervolt(gate_uv),
		.digital_supply_undervolt(dig_uv), .gate_supply_overvolt(ov),
		.temp_warning(tw), .temp_shutdown(ts), .enable_gate(en),
		.pwm_high(ph), .pwm_low(pl), .high_gate_out(gh), .low_gate_out(gl),
		.gate_weak_pulldown(wpd), .charge_pump_en(cp),
		.shutdown_fault_n_o(f_o), .shutdown_fault_n_oe(f_oe),
		.warning_n_o(w_o), .warning_n_oe(w_oe));

	gdfh_mcu_model gdfh_mcu_model_inst (
		.pclk(pclk), .fault_oe(f_oe), .warn_oe(w_oe), .req_quick(rq),
		.req_full(rf), .fault_pin_n(fpin), .warn_pin_n(wpin),
		.enable_gate(en), .busy(busy));

	// ------------------------------------------------------------
	// Compare, report and finish
	// ------------------------------------------------------------
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic results;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	always @(posedge pclk)
	begin
		if (psel && penable && pready && !pwrite && rd_q.size() > 0)
			check({pslverr, prdata} & rd_m.pop_front(), rd_q.pop_front());
		if (pin_req)
			check(33'({fpin, wpin, cp, wpd, gh, gl}) & pn_m.pop_front(), pn_q.pop_front());
	end

	// ------------------------------------------------------------
	// Drivers
	// ------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
		rd_q.push_back(e & m);
		rd_m.push_back(m);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic pins(input logic [9:0] e, input logic [9:0] m);
		pn_q.push_back(33'(e & m));
		pn_m.push_back(33'(m));
		@(posedge pclk);
		pin_req <= 1'b1;
		@(posedge pclk);
		pin_req <= 1'b0;
	endtask

	task automatic en_pulse(input logic full);
		@(posedge pclk);
		rq <= !full;
		rf <= full;
		@(posedge pclk);
		rq <= 1'b0;
		rf <= 1'b0;
		@(posedge pclk);
		while (busy === 1'b1)
			@(posedge pclk);
		cyc(6);
	endtask

	task automatic new_pwm;
		ph <= 3'h0;
		pl <= 3'h0;
		cyc(4);
		ph <= 3'($urandom);
		pl <= 3'($urandom);
		cyc(5);
	endtask

	initial
	begin
		cyc(40000);
		errors++;
		results();
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial
	begin
		{psel, penable, pwrite, pin_req, rq, rf, paddr, pwdata, oc} = '0;
		{pwr_uv, gate_uv, dig_uv, ov, tw, ts, ph, pl} = '0;
		errors = 0;
		n_checks = 0;
		presetn = 1'b0;
		k = $urandom(32'hF64F7023);
		cyc(16);
		presetn <= 1'b1;
		pins(10'h140, 10'h3FF);
		rd(CONTROL_OFS, 33'h0, '1);
		rd(8'h0C, 33'h100000000, '1);
		en_pulse(1'b1);
		for (int p = 0; p < 4; p++)
		begin
			new_pwm();
			k = $urandom_range(5, 0);
			msk = (p == 1) ? 3'(1 << (k / 2)) : 3'h0;
			apb(1'b1, CONTROL_OFS, 32'(p));
			oc[k] <= 1'b1;
			cyc(4);
			oc[k] <= 1'b0;
			ex = {p != 1, p == 3, 1'b1, p == 1, ph & ~msk, pl & ~msk};
			pins(ex, (p == 0) ? 10'h3C0 : 10'h3FF);
			rd(STATUS_OFS, 33'((p == 3) ? 0 : 1 << k) | 33'((p == 1) << 11), 33'h83F);
			rd(STATUS_OFS, 33'((p == 1) << 11), 33'h83F);
			cyc(2600);
			apb(1'b1, CONTROL_OFS, 32'(p) | 32'h10);
			new_pwm();
			pins({4'hE, ph, pl}, 10'h3FF);
		end
		for (int w = 0; w < 3; w++)
		begin
			apb(1'b1, CONTROL_OFS, 32'(w << CT_WSEL_LSB));
			tw <= 1'b1;
			cyc(5);
			pins({1'b1, w == 2, 8'h0}, 10'h300);
			rd(STATUS_OFS, 33'h200, 33'h200);
			tw <= 1'b0;
			cyc(5);
			pins(10'h300, 10'h300);
		end
		apb(1'b1, CONTROL_OFS, 32'h2);
		ts <= 1'b1;
		cyc(5);
		ts <= 1'b0;
		cyc(5);
		pins(10'h040, 10'h3C0);
		rd(CONTROL_OFS, 33'h2, '1);
		rd(STATUS_OFS, 33'h400, 33'h400);
		apb(1'b1, CONTROL_OFS, 32'h12);
		cyc(4);
		pins({4'hE, ph, pl}, 10'h3FF);
		ov <= 1'b1;
		cyc(5);
		ov <= 1'b0;
		apb(1'b1, CONTROL_OFS, 32'h12);
		cyc(4);
		pins(10'h140, 10'h3FF);
		en_pulse(1'b0);
		pins(10'h140, 10'h3FF);
		rd(STATUS_OFS, 33'h100, 33'h100);
		en_pulse(1'b1);
		pins({4'hE, ph, pl}, 10'h3FF);
		rd(CONTROL_OFS, 33'h0, '1);
		rd(STATUS_OFS, 33'h0, 33'hFFF);
		pwr_uv <= 1'b1;
		cyc(5);
		pins(10'h100, 10'h33F);
		apb(1'b1, CONTROL_OFS, 32'h1);
		rd(STATUS_OFS, 33'h100000000, '1);
		pwr_uv <= 1'b0;
		gate_uv <= 1'b1;
		cyc(5);
		pins(10'h100, 10'h33F);
		rd(STATUS_OFS, 33'h80, 33'h80);
		rd(CONTROL_OFS, 33'h0, '1);
		gate_uv <= 1'b0;
		oc[0] <= 1'b1;
		cyc(4);
		oc[0] <= 1'b0;
		dig_uv <= 1'b1;
		cyc(5);
		// Overcurrent warning pulse still runs here
		pins(10'h000, 10'h33F);
		dig_uv <= 1'b0;
		cyc(5);
		rd(STATUS_OFS, 33'h0, 33'h7FF);
		results();
	end
endmodule

bind gdfh_fault_handler gdfh_fault_handler_assertions #(.PHASES(PHASES))
	gdfh_fault_handler_assertions_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pslverr(pslverr), .power_supply_undervolt(power_supply_undervolt),
	.gate_supply_undervolt(gate_supply_undervolt),
	.digital_supply_undervolt(digital_supply_undervolt),
	.gate_supply_overvolt(gate_supply_overvolt), .temp_warning(temp_warning),
	.temp_shutdown(temp_shutdown), .enable_gate(enable_gate),
	.high_gate_out(high_gate_out), .low_gate_out(low_gate_out),
	.gate_weak_pulldown(gate_weak_pulldown), .charge_pump_en(charge_pump_en),
	.shutdown_fault_n_o(shutdown_fault_n_o), .shutdown_fault_n_oe(shutdown_fault_n_oe),
	.warning_n_o(warning_n_o), .warning_n_oe(warning_n_oe));
